//--- rtl/tcc_params.svh
// Constants for the timer capture and compare front end.
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_FILTER_SAMPLES 4
`define TCC_OUT_STATE_RESET 1'b0
`define TCC_ACT_NONE 2'h0
`define TCC_ACT_TOGGLE 2'h1
`define TCC_ACT_CLEAR 2'h2
`define TCC_ACT_SET 2'h3
`define TCC_MODE_NORMAL 4'h0
`define TCC_MODE_CTC_A 4'h4
`define TCC_MODE_CTC_CAP 4'hc
`define TCC_MODE_PWM_CAP_A 4'h8
`define TCC_MODE_PWM_CAP_B 4'ha
`define TCC_MODE_FAST_CAP 4'he
`define TCC_MODE_RSVD 4'hd
`define TCC_MODE_PWM_OCA_A 4'h9
`define TCC_MODE_PWM_OCA_B 4'hb
`define TCC_MODE_FAST_OCA 4'hf
`endif

//--- rtl/tcc_pkg.sv
// Types shared by the timer capture and compare front end.
package tcc_pkg;
    // One 8-bit register access from the processor core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] data;
    } tcc_acc_t;
    // Per-channel compare configuration.
    typedef struct packed {
        logic [1:0] action;
        logic irq_enable;
        logic force_strobe;
    } tcc_chan_cfg_t;
    // Update point of the compare buffer.
    typedef enum logic [1:0] {
        TCC_UPD_DIRECT = 2'b00,
        TCC_UPD_TOP = 2'b01,
        TCC_UPD_BOTTOM = 2'b10
    } tcc_upd_t;
endpackage

//--- rtl/tcc_capture_compare.sv
// Capture front end and two compare channels of a 16-bit timer.
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_capture_compare
    import tcc_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int FILT_N = `TCC_FILTER_SAMPLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic capture_input_pin,
    input wire logic comparator_output,
    input wire logic comparator_capture_select,
    input wire logic capture_noise_filter_enable,
    input wire logic capture_edge_select,
    input wire logic [3:0] waveform_mode_select,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic timer_tick,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic counter_write,
    input wire tcc_acc_t capture_low_acc,
    input wire tcc_acc_t capture_high_acc,
    input wire logic capture_flag_clear,
    input wire tcc_acc_t compare_value_low [2],
    input wire tcc_acc_t compare_value_high [2],
    input wire tcc_chan_cfg_t chan_cfg [2],
    input wire logic [1:0] compare_flag_clear,
    input wire logic [1:0] irq_serviced,
    output logic [7:0] read_data,
    output logic capture_flag,
    output logic [1:0] compare_flag,
    output logic [1:0] compare_irq,
    output logic [1:0] compare_output_state,
    output logic [CNT_W-1:0] compare_a_top
);
    // Refuse widths and filter depths that the logic below cannot serve.
    if (CNT_W != 16 || FILT_N < 2 || FILT_N > 8) begin
        $error("tcc_capture_compare: unsupported parameters");
    end

    // True for the twelve PWM modes, where the compare value is buffered.
    function automatic logic is_pwm(input logic [3:0] m);
        is_pwm = !(m == `TCC_MODE_NORMAL || m == `TCC_MODE_CTC_A ||
                   m == `TCC_MODE_CTC_CAP || m == `TCC_MODE_RSVD);
    endfunction

    // True where the capture register defines TOP.
    function automatic logic cap_is_top(input logic [3:0] m);
        cap_is_top = (m == `TCC_MODE_PWM_CAP_A ||
                      m == `TCC_MODE_PWM_CAP_B ||
                      m == `TCC_MODE_CTC_CAP || m == `TCC_MODE_FAST_CAP);
    endfunction

    // Buffer update point: dual-slope modes at BOTTOM, single-slope at TOP.
    function automatic tcc_upd_t upd_point(input logic [3:0] m);
        if (!is_pwm(m)) begin
            upd_point = TCC_UPD_DIRECT;
        end else if (m[3] && !m[2]) begin
            upd_point = TCC_UPD_BOTTOM;
        end else if (m[3:2] == 2'b00) begin
            upd_point = TCC_UPD_TOP;
        end else begin
            upd_point = TCC_UPD_TOP;
        end
    endfunction

    // Next output state for a match under the given action.
    function automatic logic out_next(input logic [1:0] a, input logic s);
        case (a)
            `TCC_ACT_TOGGLE: out_next = !s;
            `TCC_ACT_CLEAR: out_next = 1'b0;
            `TCC_ACT_SET: out_next = 1'b1;
            default: out_next = s;
        endcase
    endfunction

    logic trig_raw;
    logic cap_enabled;
    logic [FILT_N-1:0] samp_reg;
    logic filt_reg;
    logic prev_reg;
    logic trig_in;
    logic cap_event;
    logic [CNT_W-1:0] capture_register_reg;
    logic [7:0] temp_reg;
    logic [CNT_W-1:0] cmp_active_reg [2];
    logic [CNT_W-1:0] cmp_buffer_reg [2];
    logic block_reg;
    logic [1:0] match_pend_reg;
    logic pwm_mode;
    tcc_upd_t upd;

    // Source select; the switch itself can look like an edge.
    assign trig_raw = comparator_capture_select ? comparator_output
                                                : capture_input_pin;
    assign cap_enabled = !cap_is_top(waveform_mode_select);
    assign pwm_mode = is_pwm(waveform_mode_select);
    assign upd = upd_point(waveform_mode_select);

    // Shift register of input samples on the undivided clock.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            samp_reg <= '0;
        end else begin
            samp_reg <= {samp_reg[FILT_N-2:0], trig_raw};
        end
    end

    // Filter output moves only when all samples agree.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_reg <= 1'b0;
        end else if (&samp_reg) begin
            filt_reg <= 1'b1;
        end else if (~|samp_reg) begin
            filt_reg <= 1'b0;
        end
    end

    // The filtered path is four cycles behind the unfiltered one.
    assign trig_in = capture_noise_filter_enable ? filt_reg : samp_reg[0];

    // Edge detector history.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= trig_in;
        end
    end

    assign cap_event = cap_enabled && (trig_in != prev_reg) &&
                       (trig_in == capture_edge_select);

    // Capture register takes every event, read or not.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_register_reg <= '0;
        end else if (cap_event) begin
            capture_register_reg <= counter_value;
        end else if (!cap_enabled && capture_low_acc.wr) begin
            capture_register_reg <= {temp_reg, capture_low_acc.data};
        end
    end

    // Capture flag: a new event wins over a clear in the same cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            capture_flag <= 1'b0;
        end else if (cap_event) begin
            capture_flag <= 1'b1;
        end else if (capture_flag_clear) begin
            capture_flag <= 1'b0;
        end
    end

    // Shared high-byte latch: written on high writes, loaded on capture low reads.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_reg <= '0;
        end else if (capture_low_acc.rd) begin
            temp_reg <= capture_register_reg[15:8];
        end else if (capture_high_acc.wr) begin
            temp_reg <= capture_high_acc.data;
        end else if (compare_value_high[0].wr) begin
            temp_reg <= compare_value_high[0].data;
        end else if (compare_value_high[1].wr) begin
            temp_reg <= compare_value_high[1].data;
        end
    end

    // Read multiplexer; compare high bytes bypass the latch.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            read_data <= '0;
        end else if (capture_low_acc.rd) begin
            read_data <= capture_register_reg[7:0];
        end else if (capture_high_acc.rd) begin
            read_data <= temp_reg;
        end else if (compare_value_low[0].rd) begin
            read_data <= pwm_mode ? cmp_buffer_reg[0][7:0]
                                  : cmp_active_reg[0][7:0];
        end else if (compare_value_high[0].rd) begin
            read_data <= pwm_mode ? cmp_buffer_reg[0][15:8]
                                  : cmp_active_reg[0][15:8];
        end else if (compare_value_low[1].rd) begin
            read_data <= pwm_mode ? cmp_buffer_reg[1][7:0]
                                  : cmp_active_reg[1][7:0];
        end else if (compare_value_high[1].rd) begin
            read_data <= pwm_mode ? cmp_buffer_reg[1][15:8]
                                  : cmp_active_reg[1][15:8];
        end
    end

    // A counter write blocks matches on the next timer tick.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            block_reg <= 1'b0;
        end else if (counter_write) begin
            block_reg <= 1'b1;
        end else if (timer_tick) begin
            block_reg <= 1'b0;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [CNT_W-1:0] wval;
        logic match;
        assign wval = {temp_reg, compare_value_low[c].data};
        assign match = timer_tick && !block_reg && !counter_write &&
                       (counter_value == cmp_active_reg[c]);

        // Buffer and active compare registers; writes change them, and in PWM modes the buffer moves to active at the update point.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                cmp_buffer_reg[c] <= '0;
                cmp_active_reg[c] <= '0;
            end else begin
                if (compare_value_low[c].wr) begin
                    if (pwm_mode) begin
                        cmp_buffer_reg[c] <= wval;
                    end else begin
                        cmp_active_reg[c] <= wval;
                        cmp_buffer_reg[c] <= wval;
                    end
                end
                if (pwm_mode && timer_tick &&
                    ((upd == TCC_UPD_TOP && at_top) ||
                     (upd == TCC_UPD_BOTTOM && at_bottom))) begin
                    cmp_active_reg[c] <= cmp_buffer_reg[c];
                end
            end
        end

        // Match seen on a tick becomes the flag on the next tick.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                match_pend_reg[c] <= 1'b0;
            end else if (match) begin
                match_pend_reg[c] <= 1'b1;
            end else if (timer_tick) begin
                match_pend_reg[c] <= 1'b0;
            end
        end

        // Compare flag; setting wins over either clear.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                compare_flag[c] <= 1'b0;
            end else if (match_pend_reg[c] && timer_tick) begin
                compare_flag[c] <= 1'b1;
            end else if (compare_flag_clear[c] || irq_serviced[c]) begin
                compare_flag[c] <= 1'b0;
            end
        end

        // Interrupt request follows the flag and its enable.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                compare_irq[c] <= 1'b0;
            end else begin
                compare_irq[c] <= chan_cfg[c].irq_enable &&
                    ((match_pend_reg[c] && timer_tick) ||
                     (compare_flag[c] && !compare_flag_clear[c] &&
                      !irq_serviced[c]));
            end
        end

        // Output state; action bits used live, mode changes leave it alone.
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                compare_output_state[c] <= `TCC_OUT_STATE_RESET;
            end else if (chan_cfg[c].force_strobe && !pwm_mode) begin
                compare_output_state[c] <= out_next(chan_cfg[c].action,
                    compare_output_state[c]);
            end else if (match && !pwm_mode) begin
                compare_output_state[c] <= out_next(chan_cfg[c].action,
                    compare_output_state[c]);
            end
        end
    end

    // Channel A value offered to the counter core as TOP.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compare_a_top <= '0;
        end else begin
            compare_a_top <= cmp_active_reg[0];
        end
    end

    // Filter holds off until four equal samples are in.
    a_filter_agree: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(filt_reg) |-> ($past(samp_reg) == '0 ||
                                &$past(samp_reg)))
        else $error("filter changed without agreeing samples");

    a_capture_copy: assert property (@(posedge clk) disable iff (!reset_n)
        cap_event |=> (capture_flag &&
                       capture_register_reg == $past(counter_value)))
        else $error("capture did not copy counter and flag");

    a_capture_off_top: assert property (@(posedge clk) disable iff (!reset_n)
        (cap_is_top(waveform_mode_select) && !capture_flag)
        |=> !capture_flag)
        else $error("capture while capture register is TOP");

    // Timer ticks seen since the last counter write, saturating at two.
    logic [1:0] ticks_since_wr_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ticks_since_wr_reg <= 2'h2;
        end else if (counter_write) begin
            ticks_since_wr_reg <= 2'h0;
        end else if (timer_tick && ticks_since_wr_reg != 2'h2) begin
            ticks_since_wr_reg <= ticks_since_wr_reg + 2'h1;
        end
    end

    // The tick that a counter write must hide: same cycle or the next one.
    sequence s_tick_after_write;
        timer_tick && (counter_write || ticks_since_wr_reg == 2'h0);
    endsequence

    // A tick within a few cycles of a match, followed by the flag.
    sequence s_tick_then_flag;
        ##[1:8] timer_tick ##1 compare_flag[0];
    endsequence

    a_block_match: assert property (@(posedge clk) disable iff (!reset_n)
        s_tick_after_write
        |=> (!match_pend_reg[0] && !match_pend_reg[1]))
        else $error("match after counter write not blocked");

    a_flag_after: assert property (@(posedge clk) disable iff (!reset_n)
        g_chan[0].match |-> s_tick_then_flag)
        else $error("compare flag not set one tick after match");

    a_force_noflag: assert property (@(posedge clk) disable iff (!reset_n)
        (chan_cfg[0].force_strobe && !match_pend_reg[0] && !compare_flag[0])
        |=> !compare_flag[0])
        else $error("force strobe set compare flag");

    a_direct_write: assert property (@(posedge clk) disable iff (!reset_n)
        (compare_value_low[0].wr && !pwm_mode)
        |=> cmp_active_reg[0] == {$past(temp_reg),
                                  $past(compare_value_low[0].data)})
        else $error("low write did not load sixteen bits");

    a_buffered_hold: assert property (@(posedge clk) disable iff (!reset_n)
        (pwm_mode && !timer_tick) |=> $stable(cmp_active_reg[1]))
        else $error("buffered compare changed outside update");
endmodule

//--- dv/tcc_timer_model.sv
// Behavioural counter core that feeds the timer capture and compare front end.
`timescale 1ns/1ps
module tcc_timer_model #(
    parameter logic [15:0] TOP_VALUE = 16'h00ff
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_value,
    output logic [15:0] counter_value,
    output logic timer_tick,
    output logic at_top,
    output logic at_bottom
);
    // A processor write wins over counting, and ticks come every second cycle.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            counter_value <= 16'h0000;
            timer_tick <= 1'b0;
        end else begin
            timer_tick <= run & ~timer_tick;
            if (load) begin
                counter_value <= load_value;
            end else if (timer_tick) begin
                counter_value <= counter_value + 16'h0001;
            end
        end
    end
    // Extremes of the count as seen by the waveform logic.
    assign at_top = (counter_value == TOP_VALUE);
    assign at_bottom = (counter_value == 16'h0000);
endmodule

//--- dv/tb.sv
// Self-checking testbench for the timer capture and compare front end.
`timescale 1ns/1ps
module tb import tcc_pkg::*;;
    typedef struct packed {
        logic sel;
        logic edg;
        logic filt;
        logic [3:0] mode;
        logic [15:0] cnt;
        logic flag;
        logic [15:0] cap;
    } tcc_row_t;
    logic clk, reset_n, pin, comp, sel, filt, edge_sel, cw, run, fclr;
    logic cflag, tick, top, bot;
    logic [3:0] mode;
    logic [1:0] cclr, svc, oflag, oirq, ostate;
    logic [7:0] rdata, q;
    logic [15:0] ld_val, a_top, cnt, v;
    tcc_acc_t cap_lo, cap_hi;
    tcc_acc_t cmp_lo [2];
    tcc_acc_t cmp_hi [2];
    tcc_chan_cfg_t cfg [2];
    int n_errors, n_checks, cyc;
    tcc_row_t rows [6] = '{
        '{1'b0, 1'b1, 1'b0, 4'h0, 16'h1111, 1'b1, 16'h1111},
        '{1'b0, 1'b0, 1'b0, 4'h0, 16'h2222, 1'b1, 16'h2222},
        '{1'b1, 1'b1, 1'b0, 4'h0, 16'h3333, 1'b1, 16'h3333},
        '{1'b1, 1'b0, 1'b1, 4'h4, 16'h4444, 1'b1, 16'h4444},
        '{1'b0, 1'b1, 1'b1, 4'hc, 16'h5555, 1'b0, 16'h4444},
        '{1'b0, 1'b1, 1'b1, 4'h9, 16'h6666, 1'b1, 16'h6666}};

    tcc_timer_model i_tcc_timer_model (.clk(clk), .reset_n(reset_n),
        .run(run), .load(cw), .load_value(ld_val), .counter_value(cnt),
        .timer_tick(tick), .at_top(top), .at_bottom(bot));
    tcc_capture_compare i_tcc_capture_compare (.clk(clk), .reset_n(reset_n),
        .capture_input_pin(pin), .comparator_output(comp),
        .comparator_capture_select(sel), .capture_noise_filter_enable(filt),
        .capture_edge_select(edge_sel), .waveform_mode_select(mode),
        .counter_value(cnt), .timer_tick(tick), .at_top(top),
        .at_bottom(bot), .counter_write(cw), .capture_low_acc(cap_lo),
        .capture_high_acc(cap_hi), .capture_flag_clear(fclr),
        .compare_value_low(cmp_lo), .compare_value_high(cmp_hi),
        .chan_cfg(cfg), .compare_flag_clear(cclr), .irq_serviced(svc),
        .read_data(rdata), .capture_flag(cflag), .compare_flag(oflag),
        .compare_irq(oirq), .compare_output_state(ostate),
        .compare_a_top(a_top));

    // Free-running system clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Waits for edges, then lets their updates settle.
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [15:0] s, e);
        n_checks++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask

    // One byte access: target 0 capture, 1 compare A, 2 compare B.
    task automatic acc(input int k, input logic hi, w, input logic [7:0] d,
                       output logic [7:0] r);
        tcc_acc_t a;
        a = '{wr: w, rd: ~w, data: d};
        if (k == 0 && hi) cap_hi = a;
        else if (k == 0) cap_lo = a;
        else if (hi) cmp_hi[k - 1] = a;
        else cmp_lo[k - 1] = a;
        tk(1);
        r = rdata;
        if (k == 0 && hi) cap_hi = '0;
        else if (k == 0) cap_lo = '0;
        else if (hi) cmp_hi[k - 1] = '0;
        else cmp_lo[k - 1] = '0;
    endtask

    // Sixteen-bit read, low byte first.
    task automatic rd16(input int k, output logic [15:0] r);
        acc(k, 1'b0, 1'b0, 8'h00, r[7:0]);
        acc(k, 1'b1, 1'b0, 8'h00, r[15:8]);
    endtask

    // Sixteen-bit write, high byte first.
    task automatic wr16(input int k, input logic [15:0] d);
        acc(k, 1'b1, 1'b1, d[15:8], q);
        acc(k, 1'b0, 1'b1, d[7:0], q);
    endtask

    // Processor write of the counter.
    task automatic ld(input logic [15:0] d);
        ld_val = d;
        cw = 1'b1;
        tk(1);
        cw = 1'b0;
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    // Main sequence.
    initial begin
        {pin, comp, sel, filt, edge_sel, cw, run, fclr} = '0;
        {mode, cclr, svc, ld_val} = '0;
        {cap_lo, cap_hi} = '0;
        cmp_lo = '{default: '0};
        cmp_hi = '{default: '0};
        cfg = '{default: '0};
        reset_n = 1'b0;
        tk(8);
        reset_n = 1'b1;
        chk("reset_state", 16'(ostate), 16'h0000);
        chk("reset_flags", 16'({cflag, oflag}), 16'h0000);
        for (int i = 0; i < 6; i++) begin
            mode = rows[i].mode;
            sel = rows[i].sel;
            edge_sel = rows[i].edg;
            filt = rows[i].filt;
            pin = ~edge_sel;
            comp = ~edge_sel;
            ld(rows[i].cnt);
            tk(8);
            fclr = 1'b1;
            tk(1);
            fclr = 1'b0;
            if (sel) pin = edge_sel;
            else comp = edge_sel;
            tk(8);
            chk("other_source", 16'(cflag), 16'h0000);
            if (sel) comp = edge_sel;
            else pin = edge_sel;
            if (filt) begin
                tk(4);
                chk("filter_delay", 16'(cflag), 16'h0000);
            end
            tk(3);
            chk("capture_flag", 16'(cflag), 16'(rows[i].flag));
            rd16(0, v);
            chk("capture_value", v, rows[i].cap);
        end
        // A short pulse through the filter, then two unread captures.
        mode = 4'h0;
        sel = 1'b0;
        edge_sel = 1'b1;
        filt = 1'b1;
        pin = 1'b0;
        tk(8);
        fclr = 1'b1;
        tk(1);
        fclr = 1'b0;
        pin = 1'b1;
        tk(3);
        pin = 1'b0;
        tk(10);
        chk("glitch", 16'(cflag), 16'h0000);
        filt = 1'b0;
        ld(16'h0abc);
        pin = 1'b1;
        tk(4);
        ld(16'h0def);
        edge_sel = 1'b0;
        fclr = 1'b1;
        tk(1);
        fclr = 1'b0;
        pin = 1'b0;
        tk(4);
        rd16(0, v);
        chk("overwrite", v, 16'h0def);
        // Byte-ordered compare writes and direct high reads.
        acc(1, 1'b1, 1'b1, 8'h12, q);
        tk(2);
        chk("half_write", a_top, 16'h0000);
        acc(1, 1'b0, 1'b1, 8'h34, q);
        tk(2);
        chk("direct_write", a_top, 16'h1234);
        acc(0, 1'b0, 1'b0, 8'h00, q);
        acc(1, 1'b1, 1'b0, 8'h00, q);
        chk("direct_high", {8'h00, q}, 16'h0012);
        // Forced compares set up the output state for each action.
        for (int i = 0; i < 4; i++) begin
            cfg[0].action = 2'(3 - i);
            cfg[0].force_strobe = 1'b1;
            tk(1);
            cfg[0].force_strobe = 1'b0;
            tk(1);
            chk("force_state", 16'(ostate[0]),
                16'((4'b1101 >> i) & 4'b0001));
            chk("force_flag", 16'(oflag), 16'h0000);
        end
        mode = 4'he;
        cfg[0].action = 2'h1;
        cfg[0].force_strobe = 1'b1;
        tk(1);
        cfg[0].force_strobe = 1'b0;
        tk(1);
        chk("pwm_force", 16'(ostate[0]), 16'h0001);
        mode = 4'h0;
        tk(1);
        chk("mode_keep", 16'(ostate[0]), 16'h0001);
        // Real matches on both channels, interrupt on A only.
        cfg[0].irq_enable = 1'b1;
        wr16(1, 16'h0105);
        wr16(2, 16'h0105);
        ld(16'h0100);
        run = 1'b1;
        for (int k = 0; k < 40 && oflag[0] !== 1'b1; k++) tk(1);
        chk("match_time", cnt, 16'h0107);
        chk("match_flags", 16'(oflag), 16'h0003);
        chk("match_irq", 16'(oirq), 16'h0001);
        chk("match_state", 16'(ostate[0]), 16'h0000);
        run = 1'b0;
        svc = 2'b01;
        cclr = 2'b10;
        tk(1);
        svc = 2'b00;
        cclr = 2'b00;
        tk(1);
        chk("flag_clear", 16'({oflag, oirq}), 16'h0000);
        // A counter write hides the match on the next tick.
        run = 1'b1;
        ld(16'h0105);
        tk(12);
        run = 1'b0;
        chk("blocked", 16'(oflag), 16'h0000);
        // Buffered compare in a PWM mode is taken over at TOP.
        mode = 4'hf;
        wr16(1, 16'h00f8);
        tk(2);
        chk("buffered", a_top, 16'h0105);
        rd16(1, v);
        chk("buffer_read", v, 16'h00f8);
        ld(16'h00fc);
        run = 1'b1;
        tk(16);
        run = 1'b0;
        chk("top_update", a_top, 16'h00f8);
        // Dual-slope PWM takes the buffer over at BOTTOM instead.
        mode = 4'h9;
        wr16(1, 16'h0042);
        ld(16'h0000);
        chk("bottom_hold", a_top, 16'h00f8);
        run = 1'b1;
        tk(6);
        run = 1'b0;
        chk("bottom_update", a_top, 16'h0042);
        conclude();
    end
endmodule
